// [pkg/drp_map.vh]
`ifndef DRP_MAP_VH
`define DRP_MAP_VH
// PCI bus commands.
`define DRP_CMD_IO_RD 4'h2
`define DRP_CMD_MEM_RD 4'h6
`define DRP_CMD_CFG_RD 4'hA
`define DRP_CMD_MRM 4'hC
`define DRP_CMD_MRL 4'hE
// Prefetch boundaries in DWORDs.
`define DRP_BND_DEFAULT 10'h010
`define DRP_BND_MRM_DEFAULT 10'h020
`define DRP_BND_FLOW 11'h400
`define DRP_BE_ALL_ON 4'h0
`define DRP_QUEUE_DEPTH 4
`define DRP_FIFO_DEPTH 4
`endif

// [hdl/drp_req_queue.v]
`timescale 1ns/1ps
// Delayed read request queue with duplicate detection.
module drp_req_queue #(
	parameter DEPTH = 4,
	parameter IW = 2
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Push side
	input wire push,
	input wire [31:0] push_addr,
	input wire [3:0] push_cmd,
	input wire push_par,
	input wire [3:0] push_be,
	output wire full,
	output reg dup,
	// Pop side
	input wire pop,
	output wire head_valid,
	output wire [31:0] head_addr,
	output wire [3:0] head_cmd,
	output wire [3:0] head_be,
	output wire head_par
);
	reg [31:0] addr_reg [0:DEPTH-1];
	reg [3:0] cmd_reg [0:DEPTH-1];
	reg [3:0] be_reg [0:DEPTH-1];
	reg [DEPTH-1:0] par_reg;
	reg [DEPTH-1:0] vld_reg;
	reg [IW-1:0] wp_reg;
	reg [IW-1:0] rp_reg;
	wire [DEPTH-1:0] hit;
	integer k;

	assign full = &vld_reg;
	assign head_valid = vld_reg[rp_reg];
	assign head_addr = addr_reg[rp_reg];
	assign head_cmd = cmd_reg[rp_reg];
	assign head_be = be_reg[rp_reg];
	assign head_par = par_reg[rp_reg];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_cmp
			assign hit[g] = vld_reg[g] && addr_reg[g] == push_addr &&
				cmd_reg[g] == push_cmd;
		end
	endgenerate

	always @* begin
		dup = |hit;
	end

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			vld_reg <= {DEPTH{1'b0}};
			wp_reg <= {IW{1'b0}};
			rp_reg <= {IW{1'b0}};
			par_reg <= {DEPTH{1'b0}};
			for (k = 0; k < DEPTH; k = k + 1) begin
				addr_reg[k] <= 32'h0;
				cmd_reg[k] <= 4'h0;
				be_reg[k] <= 4'h0;
			end
		end else begin
			if (pop && head_valid) begin
				vld_reg[rp_reg] <= 1'b0;
				rp_reg <= rp_reg + 1'b1;
			end
			if (push && !full && !dup) begin
				addr_reg[wp_reg] <= push_addr;
				cmd_reg[wp_reg] <= push_cmd;
				be_reg[wp_reg] <= push_be;
				par_reg[wp_reg] <= push_par;
				vld_reg[wp_reg] <= 1'b1;
				wp_reg <= wp_reg + 1'b1;
			end
		end
	end
endmodule // drp_req_queue

// [hdl/drp_fifo.v]
`timescale 1ns/1ps
// Read data FIFO facing the initiator bus.
module drp_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock, reset and flush
	input wire ref_clk,
	input wire reset,
	input wire flush,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] free_cnt
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wp_reg;
	reg [AW-1:0] rp_reg;
	reg [AW:0] cnt_reg;
	wire wr = in_valid && in_ready;
	wire rd = out_valid && out_ready;
	integer k;

	assign in_ready = cnt_reg != DEPTH[AW:0];
	assign out_valid = cnt_reg != {(AW+1){1'b0}};
	assign out_data = mem_reg[rp_reg];
	assign free_cnt = DEPTH[AW:0] - cnt_reg;

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wp_reg <= {AW{1'b0}};
			rp_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
			for (k = 0; k < DEPTH; k = k + 1)
				mem_reg[k] <= {WIDTH{1'b0}};
		end else if (flush) begin
			wp_reg <= {AW{1'b0}};
			rp_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (wr) begin
				mem_reg[wp_reg] <= in_data;
				wp_reg <= wp_reg + 1'b1;
			end
			if (rd)
				rp_reg <= rp_reg + 1'b1;
			if (wr && !rd)
				cnt_reg <= cnt_reg + 1'b1;
			else if (rd && !wr)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule // drp_fifo

// [hdl/drp_ctrl.v]
`timescale 1ns/1ps
`include "drp_map.vh"
// Functional notes
// - Every crossing read is a delayed transaction.
// - Prefetch reads enable all byte lanes.
// - Prefetch MRL, MRM, prefetchable memory reads.
// - Non-prefetch fetches one DWORD, then disconnects.
// - Non-prefetch forwards captured byte enables.
// - I/O, config, non-prefetch memory: single DWORD.
// - Prefetch limited by free buffer space.
// - Stop at boundary or target disconnect.
// - Disconnect with last prefetched data.
// - Drop untaken prefetched data at end.
// - Flow-through fetches to 4KB or FRAME release; code measures 4KB from the offset of queue head q_addr, not tgt_addr_reg.
// - MR/MRL with size 0/16: 16 DWORDs.
// - MRM with size 0/16: 32 DWORDs.
// - MR/MRL power-of-two size from 1 to 16: cache line.
// - MRM power-of-two size from 1 to 16: twice cache line.
// - Plain reads: downstream by space, upstream setting.
// - Capture address, command, parity, then byte enables.
// - Retry initiator after capturing request.
// - Hold data until initiator repeats read.
// - Prefetch drives byte enables all low.
// - Four outstanding; duplicates not requeued.
module drp_ctrl #(
	parameter QDEPTH = `DRP_QUEUE_DEPTH,
	parameter FDEPTH = `DRP_FIFO_DEPTH
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Configuration
	input wire [7:0] line_size_dwords,
	input wire downstream,
	input wire upstream_prefetch_en,
	// Initiator bus request
	input wire init_addr_valid,
	input wire [31:0] init_addr,
	input wire [3:0] init_cmd,
	input wire init_par,
	input wire init_prefetchable,
	input wire init_irdy,
	input wire [3:0] init_be_n,
	input wire init_frame,
	output wire init_retry,
	output wire init_trdy,
	output wire init_stop,
	output wire [31:0] init_data,
	// Target bus read execution
	output wire tgt_req_valid,
	input wire tgt_req_take,
	output reg [31:0] tgt_addr_reg,
	output reg [3:0] tgt_cmd_reg,
	output reg tgt_par_reg,
	output reg [3:0] tgt_be_n_reg,
	output reg [10:0] tgt_count_reg,
	input wire tgt_data_valid,
	output wire tgt_data_ready,
	input wire [31:0] tgt_data,
	input wire tgt_disconnect,
	output reg tgt_busy_reg
);
	// ----------------------------------------------------------------
	// Capture state
	// ----------------------------------------------------------------
	localparam ST_IDLE = 2'b00;
	localparam ST_ADDR = 2'b01;
	localparam ST_RETRY = 2'b10;
	localparam ST_XFER = 2'b11;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [31:0] cap_addr_reg;
	reg [3:0] cap_cmd_reg;
	reg cap_par_reg;
	reg cap_pref_reg;
	reg match_reg;
	reg flow_reg;
	reg [10:0] left_reg;
	reg [31:0] dat_reg;
	reg xfer_reg;

	wire q_full;
	wire q_dup;
	wire q_valid;
	wire [31:0] q_addr;
	wire [3:0] q_cmd;
	wire [3:0] q_be;
	wire q_par;
	wire f_in_ready;
	wire f_out_valid;
	wire [31:0] f_out_data;
	wire [2:0] f_free;
	wire f_pop;
	wire flush;
	wire q_push;
	wire q_pop;
	wire head_pref;
	wire is_mem;
	wire [10:0] bnd;
	wire [10:0] dw_off;
	wire [10:0] to_bnd;
	wire [10:0] flow_len;
	wire last_beat;

	// ----------------------------------------------------------------
	// Classification
	// ----------------------------------------------------------------
	function pref_of;
		input [3:0] cmd;
		input pspace;
		begin
			case (cmd)
				`DRP_CMD_MRL: pref_of = 1'b1;
				`DRP_CMD_MRM: pref_of = 1'b1;
				`DRP_CMD_MEM_RD: pref_of = downstream ? pspace :
					upstream_prefetch_en;
				default: pref_of = 1'b0;
			endcase
		end
	endfunction

	function [10:0] bnd_of;
		input [3:0] cmd;
		input [7:0] ls;
		reg pow;
		begin
			pow = ls == 8'h01 || ls == 8'h02 || ls == 8'h04 ||
				ls == 8'h08 || ls == 8'h10;
			bnd_of = 11'h001;
			if (cmd == `DRP_CMD_MRM && !pow)
				bnd_of = {1'b0, `DRP_BND_MRM_DEFAULT};
			else if (cmd == `DRP_CMD_MRM)
				bnd_of = {2'b00, ls, 1'b0};
			else if (!pow)
				bnd_of = {1'b0, `DRP_BND_DEFAULT};
			else
				bnd_of = {3'b000, ls};
		end
	endfunction

	assign is_mem = init_cmd == `DRP_CMD_MEM_RD ||
		init_cmd == `DRP_CMD_MRL || init_cmd == `DRP_CMD_MRM;
	assign head_pref = pref_of(q_cmd, q_addr[31] ? 1'b1 : cap_pref_reg);
	assign bnd = bnd_of(q_cmd, line_size_dwords);
	assign dw_off = {1'b0, q_addr[11:2]};
	assign to_bnd = bnd - (dw_off & (bnd - 11'h001));
	assign flow_len = `DRP_BND_FLOW - dw_off;

	// ----------------------------------------------------------------
	// Initiator side state machine
	// ----------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (init_addr_valid)
				state_next = ST_ADDR;
			ST_ADDR: if (init_irdy)
				state_next = match_reg ? ST_XFER : ST_RETRY;
			ST_RETRY: state_next = ST_IDLE;
			ST_XFER: if (!init_frame || last_beat || !f_out_valid)
				state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			cap_addr_reg <= 32'h0;
			cap_cmd_reg <= 4'h0;
			cap_par_reg <= 1'b0;
			cap_pref_reg <= 1'b0;
			match_reg <= 1'b0;
			xfer_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			xfer_reg <= state_next == ST_XFER;
			if (state_reg == ST_IDLE && init_addr_valid) begin
				cap_addr_reg <= init_addr;
				cap_cmd_reg <= init_cmd;
				cap_par_reg <= init_par;
				cap_pref_reg <= init_prefetchable;
				// Memory read commands alias when matching.
				match_reg <= tgt_busy_reg || f_out_valid ?
					init_addr == tgt_addr_reg &&
					(is_mem ? 1'b1 : init_cmd == tgt_cmd_reg) : 1'b0;
			end
		end
	end

	assign q_push = state_reg == ST_ADDR && init_irdy && !match_reg;
	assign init_retry = state_reg == ST_RETRY;

	drp_req_queue #(
		.DEPTH(QDEPTH),
		.IW(2)
	) u_queue (
		.ref_clk(ref_clk),
		.reset(reset),
		.push(q_push),
		.push_addr(cap_addr_reg),
		.push_cmd(cap_cmd_reg),
		.push_par(cap_par_reg),
		.push_be(init_be_n),
		.full(q_full),
		.dup(q_dup),
		.pop(q_pop),
		.head_valid(q_valid),
		.head_addr(q_addr),
		.head_cmd(q_cmd),
		.head_be(q_be),
		.head_par(q_par)
	);

	// ----------------------------------------------------------------
	// Target side launch
	// ----------------------------------------------------------------
	assign tgt_req_valid = q_valid && !tgt_busy_reg && !f_out_valid;
	assign q_pop = tgt_req_valid && tgt_req_take;

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			tgt_addr_reg <= 32'h0;
			tgt_cmd_reg <= 4'h0;
			tgt_par_reg <= 1'b0;
			tgt_be_n_reg <= 4'hF;
			tgt_count_reg <= 11'h0;
			tgt_busy_reg <= 1'b0;
			left_reg <= 11'h0;
			flow_reg <= 1'b0;
		end else if (q_pop) begin
			tgt_addr_reg <= q_addr;
			tgt_cmd_reg <= q_cmd;
			tgt_par_reg <= q_par;
			tgt_busy_reg <= 1'b1;
			flow_reg <= 1'b0;
			if (head_pref) begin
				tgt_be_n_reg <= `DRP_BE_ALL_ON;
				tgt_count_reg <= to_bnd;
				left_reg <= to_bnd;
			end else begin
				tgt_be_n_reg <= q_be;
				tgt_count_reg <= 11'h001;
				left_reg <= 11'h001;
			end
		end else if (tgt_busy_reg) begin
			if (xfer_reg && !flow_reg &&
				tgt_be_n_reg == `DRP_BE_ALL_ON) begin
				flow_reg <= 1'b1;
				left_reg <= flow_len - (tgt_count_reg - left_reg);
			end else if (tgt_data_valid && f_in_ready) begin
				left_reg <= left_reg - 11'h001;
			end
			if (tgt_disconnect || (left_reg == 11'h001 &&
				tgt_data_valid && f_in_ready) ||
				(flow_reg && !init_frame) || flush)
				tgt_busy_reg <= 1'b0;
		end
	end

	assign tgt_data_ready = tgt_busy_reg && f_in_ready &&
		left_reg != 11'h000;

	// ----------------------------------------------------------------
	// Read data buffer
	// ----------------------------------------------------------------
	drp_fifo #(
		.WIDTH(32),
		.DEPTH(FDEPTH),
		.AW(2)
	) u_fifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.flush(flush),
		.in_valid(tgt_data_valid && tgt_data_ready),
		.in_ready(f_in_ready),
		.in_data(tgt_data),
		.out_valid(f_out_valid),
		.out_ready(f_pop),
		.out_data(f_out_data),
		.free_cnt(f_free)
	);

	assign f_pop = state_reg == ST_XFER && init_irdy && f_out_valid;
	assign last_beat = !tgt_busy_reg && f_free == 3'd3;
	// drop untaken data
	// An initiator that ends its burst also ends a running fetch, so
	// no stale data can block the next launch.
	assign flush = state_reg == ST_XFER && state_next == ST_IDLE &&
		(!tgt_busy_reg || !init_frame) && !(f_pop && last_beat);

	always @(posedge ref_clk or posedge reset) begin
		if (reset)
			dat_reg <= 32'h0;
		else if (f_pop)
			dat_reg <= f_out_data;
	end

	assign init_data = f_out_data;
	assign init_trdy = f_pop;
	assign init_stop = state_reg == ST_XFER &&
		(last_beat || !f_out_valid);
endmodule // drp_ctrl

// [test/drp_ctrl_asserts.sv]
`timescale 1ns/1ps
`include "drp_map.vh"
module drp_ctrl_asserts (
	// Watched ports
	input wire ref_clk,
	input wire reset,
	input wire [7:0] line_size_dwords,
	input wire init_addr_valid,
	input wire init_irdy,
	input wire init_retry,
	input wire init_trdy,
	input wire init_stop,
	input wire tgt_req_take,
	input wire [31:0] tgt_addr_reg,
	input wire [3:0] tgt_cmd_reg,
	input wire [3:0] tgt_be_n_reg,
	input wire [10:0] tgt_count_reg,
	input wire tgt_busy_reg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_req;
		init_addr_valid ##1 init_irdy;
	endsequence
	sequence s_go;
		$rose(tgt_busy_reg);
	endsequence
	a_req_answer: assert property (s_req |=> init_retry | init_trdy | init_stop)
		else $error("request got no answer");
	a_retry_once: assert property (init_retry |=> !init_retry)
		else $error("retry held too long");
	a_launch_cause: assert property (s_go |-> $past(tgt_req_take))
		else $error("fetch without take");
	a_io_single: assert property (s_go ##0 tgt_cmd_reg == `DRP_CMD_IO_RD
		|-> tgt_count_reg == 11'h001) else $error("io count");
	a_cfg_single: assert property (s_go ##0 tgt_cmd_reg == `DRP_CMD_CFG_RD
		|-> tgt_count_reg == 11'h001) else $error("cfg count");
	a_pf_lanes_on: assert property (s_go ##0
		(tgt_cmd_reg == `DRP_CMD_MRL || tgt_cmd_reg == `DRP_CMD_MRM)
		|-> tgt_be_n_reg == `DRP_BE_ALL_ON) else $error("prefetch lanes");
	a_mrl_line: assert property (s_go ##0 tgt_cmd_reg == `DRP_CMD_MRL
		&& line_size_dwords == 8'h08 |-> tgt_count_reg == 11'h008 -
		tgt_addr_reg[4:2]) else $error("line boundary");
	a_mrl_sixteen: assert property (s_go ##0 tgt_cmd_reg == `DRP_CMD_MRL
		&& line_size_dwords == 8'h10 |-> tgt_count_reg == 11'h010 -
		tgt_addr_reg[5:2]) else $error("16 boundary");
	a_mrm_double: assert property (s_go ##0 tgt_cmd_reg == `DRP_CMD_MRM
		&& line_size_dwords == 8'h04 |-> tgt_count_reg == 11'h008 -
		tgt_addr_reg[4:2]) else $error("2x boundary");
	a_mrm_32: assert property (s_go ##0 tgt_cmd_reg == `DRP_CMD_MRM
		&& line_size_dwords == 8'h00 |-> tgt_count_reg == 11'h020 -
		tgt_addr_reg[6:2]) else $error("32 boundary");
endmodule // drp_ctrl_asserts
bind drp_ctrl drp_ctrl_asserts i_drp_ctrl_asserts (.ref_clk, .reset,
	.line_size_dwords, .init_addr_valid, .init_irdy, .init_retry,
	.init_trdy, .init_stop, .tgt_req_take, .tgt_addr_reg, .tgt_cmd_reg,
	.tgt_be_n_reg, .tgt_count_reg, .tgt_busy_reg);

// [test/drp_tgt_model.sv]
`timescale 1ns/1ps
module drp_tgt_model (
	input wire ref_clk,
	input wire reset,
	input wire slow,
	input wire [10:0] disc_at,
	input wire tgt_req_valid,
	input wire tgt_busy_reg,
	input wire [31:0] tgt_addr_reg,
	input wire tgt_data_ready,
	output reg tgt_req_take,
	output reg tgt_data_valid,
	output reg [31:0] tgt_data,
	output reg tgt_disconnect
);
	reg [10:0] beat_reg;
	wire [10:0] beat_next = beat_reg + 11'h001;
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			tgt_req_take <= 1'b0;
			tgt_data_valid <= 1'b0;
			tgt_data <= 32'h0;
			tgt_disconnect <= 1'b0;
			beat_reg <= 11'h000;
		end else begin
			tgt_req_take <= tgt_req_valid && !tgt_busy_reg && !tgt_req_take;
			tgt_disconnect <= 1'b0;
			if (tgt_data_valid && tgt_data_ready) begin
				beat_reg <= beat_next;
				tgt_disconnect <= beat_next == disc_at;
				tgt_data_valid <= !slow && beat_next != disc_at;
				tgt_data <= slow ? ~tgt_data : tgt_addr_reg + {beat_next, 2'b00};
			end else if (!tgt_busy_reg) begin
				tgt_data_valid <= 1'b0;
				tgt_data <= ~tgt_data;
				beat_reg <= 11'h000;
			end else if (!tgt_data_valid && beat_reg != disc_at) begin
				tgt_data_valid <= 1'b1;
				tgt_data <= tgt_addr_reg + {beat_reg, 2'b00};
			end
		end
	end
endmodule // drp_tgt_model

// [test/delayed_read_prefetch_control_tb.sv]
`timescale 1ns/1ps
`include "drp_map.vh"
module delayed_read_prefetch_control_tb;
	reg ref_clk, reset, dn, up_pf, av, irdy, frame, par, pf, slow, bq, pe;
	reg [7:0] ls;
	reg [31:0] addr, seed, a;
	reg [3:0] cmd, be_n;
	reg [10:0] disc_at, n, t;
	reg [12:0] tc;
	wire retry, trdy, stop, rv, take, dv, dr, disc, busy;
	wire [31:0] idata, taddr, tdata;
	wire [3:0] tcmd, tbe;
	wire [10:0] tcnt;
	integer err_count, checked, i, k, got;
	reg [31:0] dq[$];
	reg [50:0] lq[$];
	drp_ctrl i_drp_ctrl (.ref_clk(ref_clk), .reset(reset),
		.line_size_dwords(ls), .downstream(dn), .upstream_prefetch_en(up_pf),
		.init_addr_valid(av), .init_addr(addr), .init_cmd(cmd),
		.init_par(par), .init_prefetchable(pf), .init_irdy(irdy),
		.init_be_n(be_n), .init_frame(frame), .init_retry(retry),
		.init_trdy(trdy), .init_stop(stop), .init_data(idata),
		.tgt_req_valid(rv), .tgt_req_take(take), .tgt_addr_reg(taddr),
		.tgt_cmd_reg(tcmd), .tgt_par_reg(), .tgt_be_n_reg(tbe),
		.tgt_count_reg(tcnt), .tgt_data_valid(dv), .tgt_data_ready(dr),
		.tgt_data(tdata), .tgt_disconnect(disc), .tgt_busy_reg(busy));
	drp_tgt_model i_drp_tgt_model (.ref_clk(ref_clk), .reset(reset),
		.slow(slow), .disc_at(disc_at), .tgt_req_valid(rv),
		.tgt_busy_reg(busy), .tgt_addr_reg(taddr), .tgt_data_ready(dr),
		.tgt_req_take(take), .tgt_data_valid(dv), .tgt_data(tdata),
		.tgt_disconnect(disc));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	function [31:0] xs(input [31:0] x);
		reg [31:0] y;
		begin
			y = x ^ (x << 13);
			y = y ^ (y >> 17);
			xs = y ^ (y << 5);
		end
	endfunction
	function [12:0] tcase(input integer j);
		case (j)
			0: tcase = {`DRP_CMD_IO_RD, 1'b0, 8'h08};
			1: tcase = {`DRP_CMD_CFG_RD, 1'b0, 8'h10};
			2: tcase = {`DRP_CMD_MEM_RD, 1'b0, 8'h00};
			3: tcase = {`DRP_CMD_MEM_RD, 1'b1, 8'h00};
			4: tcase = {`DRP_CMD_MRL, 1'b0, 8'h08};
			5: tcase = {`DRP_CMD_MRL, 1'b1, 8'h10};
			6: tcase = {`DRP_CMD_MRM, 1'b0, 8'h04};
			9: tcase = {`DRP_CMD_MEM_RD, 1'b0, 8'h08};
			default: tcase = {`DRP_CMD_MRM, 1'b0, 8'h00};
		endcase
	endfunction
	task cmp_launch(input [50:0] e, input [50:0] s);
		checked = checked + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("FAIL launch exp %h got %h", e, s);
		end
	endtask
	task cmp_data(input [31:0] e, input [31:0] s);
		checked = checked + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("FAIL data exp %h got %h", e, s);
		end
	endtask
	task cmp_flag(input e, input s, input [47:0] nm);
		checked = checked + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("FAIL %0s exp %b got %b", nm, e, s);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		if (busy === 1'b1 && bq !== 1'b1)
			cmp_launch(lq.size() ? lq.pop_front() : 51'bx, {taddr, tcmd, tbe, tcnt});
		if (trdy === 1'b1 && irdy === 1'b1)
			cmp_data(dq.size() ? dq.pop_front() : 32'bx, idata);
		bq = busy;
	end
	// ----------------------------------------
	// Initiator bus cycles
	// ----------------------------------------
	task req;
		@(posedge ref_clk);
		av <= 1'b1;
		addr <= a;
		cmd <= tc[12:9];
		pf <= tc[8];
		par <= ^{a, tc[12:9]};
		frame <= 1'b1;
		@(posedge ref_clk);
		av <= 1'b0;
		irdy <= 1'b1;
		frame <= 1'b0;
		be_n <= seed[11:8];
		k = 0;
		do begin
			@(negedge ref_clk);
			k = k + 1;
		end while (retry !== 1'b1 && k < 4);
		cmp_flag(1'b1, retry, "retry");
		@(posedge ref_clk);
		irdy <= 1'b0;
	endtask
	task rep(input chk);
		for (k = 0; k < t; k = k + 1)
			dq.push_back(a + {k[29:0], 2'b00});
		@(posedge ref_clk);
		av <= 1'b1;
		frame <= 1'b1;
		@(posedge ref_clk);
		av <= 1'b0;
		irdy <= 1'b1;
		frame <= t > 11'h001;
		got = 0;
		k = 0;
		while (got < t && k < 40) begin
			@(negedge ref_clk);
			k = k + 1;
			if (trdy === 1'b1) begin
				got = got + 1;
				if (got == t && chk)
					cmp_flag(1'b1, stop, "stop");
				if (got == t - 1) begin
					@(posedge ref_clk);
					frame <= 1'b0;
				end
			end
		end
		cmp_flag(1'b1, got == t, "beats");
		@(posedge ref_clk);
		irdy <= 1'b0;
		frame <= 1'b0;
		@(negedge ref_clk);
		dq.delete();
	endtask
	initial begin
		{av, irdy, frame, par, pf, slow, up_pf, bq} = 8'h00;
		dn = 1'b1;
		ls = 8'h08;
		addr = 32'h0;
		cmd = 4'h0;
		be_n = 4'hF;
		disc_at = 11'h7FF;
		err_count = 0;
		checked = 0;
		seed = 32'h5D6E4E80;
		reset = 1'b1;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		for (i = 0; i < 10; i = i + 1) begin
			seed = xs(seed);
			tc = tcase(i);
			a = {1'b0, seed[30:7], i == 8 ? 5'h00 : seed[6:2], 2'b00};
			slow <= seed[0];
			disc_at <= i == 8 ? 11'h002 : 11'h7FF;
			ls <= tc[7:0];
			dn <= i != 9;
			up_pf <= i == 9;
			pe = tc[12:9] == `DRP_CMD_MRL || tc[12:9] == `DRP_CMD_MRM ||
				tc[12:9] == `DRP_CMD_MEM_RD && (i == 9 || tc[8]);
			n = 11'h001;
			if (pe) begin
				n = (tc[7:0] == 8'h00 || tc[7:0] == 8'h10) ? 11'h010 : {3'h0, tc[7:0]};
				n = tc[12:9] == `DRP_CMD_MRM ? n << 1 : n;
				n = n - (a[12:2] % n);
			end
			lq.push_back({a, tc[12:9], pe ? 4'h0 : seed[11:8], n});
			req;
			k = 0;
			while ((lq.size() != 0 || dr === 1'b1) && k < 60) begin
				@(posedge ref_clk);
				k = k + 1;
			end
			cmp_flag(1'b1, k < 60, "fetch");
			t = n < 2 ? n : 11'h002;
			rep(t == n || i == 8);
			$display("test %0d done", i);
		end
		repeat (20) @(posedge ref_clk);
		cmp_flag(1'b0, lq.size() != 0, "launch");
		end_of_test;
	end
	initial begin
		#(4 * 20000);
		err_count = err_count + 1;
		end_of_test;
	end
endmodule // delayed_read_prefetch_control_tb
